// *** rtl/kvf_consts.vh ***
// constants for the key-version / file-settings command interpreter
// assumes a 32-bit ahb-lite register bus, word aligned offsets
`ifndef KVF_CONSTS_VH
`define KVF_CONSTS_VH
// register byte offsets
`define KVF_OFF_CTRL 8'h00
`define KVF_OFF_FRAME0 8'h04
`define KVF_OFF_FRAME1 8'h08
`define KVF_OFF_FRAME2 8'h0C
`define KVF_OFF_LEN 8'h10
`define KVF_OFF_KVER0 8'h14
`define KVF_OFF_KVER1 8'h18
`define KVF_OFF_FILES 8'h1C
`define KVF_OFF_TXNFILE 8'h20
`define KVF_OFF_TXNCTR 8'h24
`define KVF_OFF_FSET 8'h28
`define KVF_OFF_LIMIT 8'h2C
`define KVF_OFF_STATUS 8'h30
// ctrl bit positions
`define KVF_C_START 0
`define KVF_C_CHAIN 1
`define KVF_C_MACOK 2
`define KVF_C_NVMFAIL 3
`define KVF_C_CARD 4
`define KVF_C_MAUTH 5
`define KVF_C_LRP 6
`define KVF_C_CHGFREE 7
`define KVF_C_CHGNEVER 8
`define KVF_C_CHGAUTH 9
`define KVF_C_ENC 10
`define KVF_CTRL_RST 11'h004
// command codes
`define KVF_CMD_KEYREP 8'hC4
`define KVF_CMD_KVQ 8'h64
`define KVF_CMD_FSU 8'h5F
// status bytes
`define KVF_SW1 8'h91
`define KVF_ST_OK 8'h00
`define KVF_ST_ABORT 8'hCA
`define KVF_ST_INTEG 8'h1E
`define KVF_ST_LEN 8'h7E
`define KVF_ST_PARAM 8'h9E
`define KVF_ST_NOKEY 8'h40
`define KVF_ST_DENY 8'h9D
`define KVF_ST_AUTH 8'hAE
`define KVF_ST_NVM 8'hEE
`define KVF_ST_NOFILE 8'hF0
`define KVF_ST_ILLCMD 8'h1C
// frame lengths in bytes, command byte included; the limit lengths count the limit bytes only
`define KVF_LEN_KEYREP 4'h3
`define KVF_LEN_KVQ 4'h2
`define KVF_LEN_FSU 4'h5
`define KVF_LEN_LIM_AES 4'h4
`define KVF_LEN_LIM_LRP 4'h2
`define KVF_MAX_KEY 6'h04
`define KVF_ORIGIN_KVER 8'h00
`endif

// *** rtl/kvf_cmd.v ***
// key replacement, key version query and file settings update interpreter
// assumes one ahb-lite master, 32-bit words; the frame is loaded by software
// frame and length must be in place before the start strobe; the ctrl session bits are written with it
//
// The address map and register access over AHB-Lite were decided locally.
`include "kvf_consts.vh"
module kvf_cmd (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp
);
  localparam ST_IDLE = 2'b01;
  localparam ST_EXEC = 2'b10;

  // sequencer state, one-hot
  reg [1:0] state_reg;

  // context, frame and key store written by software
  reg [10:0] ctrl_reg;
  reg [31:0] frame0_reg;
  reg [31:0] frame1_reg;
  reg [7:0] frame2_reg;
  reg [3:0] len_reg;
  reg [39:0] kver_reg;
  reg [31:0] files_reg;
  reg [4:0] txn_file_reg;
  reg [31:0] txn_ctr_reg;

  // results of the last command, read only
  reg [31:0] fset_reg;
  reg [31:0] limit_reg;
  reg [7:0] sw2_reg;
  reg [7:0] reply_reg;
  reg done_reg;

  // bus data-phase bookkeeping
  reg wr_pend_reg;
  reg rd_pend_reg;
  reg [7:0] addr_reg;

  // combinational results
  reg [7:0] sw2_next;
  reg [7:0] kq_ver;
  reg [31:0] rd_mux;

  // frame byte view: byte 0 is the command code
  wire [7:0] cmd_b = frame0_reg[7:0];
  wire [7:0] idx_b = frame0_reg[15:8];
  wire [7:0] opt_b = frame0_reg[23:16];
  wire [15:0] acc_set = {frame1_reg[7:0], frame0_reg[31:24]};
  wire [4:0] file_index = idx_b[4:0];
  wire is_txn_file = (file_index == txn_file_reg);
  wire lim_on = opt_b[5];
  // limit bytes arrive low byte first
  wire [31:0] txn_counter_limit = ctrl_reg[`KVF_C_LRP] ?
    {16'h0000, frame1_reg[23:8]} : {frame2_reg, frame1_reg[31:8]};
  wire [3:0] lim_len = ctrl_reg[`KVF_C_LRP] ? `KVF_LEN_LIM_LRP : `KVF_LEN_LIM_AES;
  wire [3:0] fsu_len = lim_on ? (`KVF_LEN_FSU + lim_len) : `KVF_LEN_FSU;

  // file settings checks, named so the priority chain below stays short
  wire fsu_mode_bad = (ctrl_reg[`KVF_C_ENC] == ctrl_reg[`KVF_C_CHGFREE]);
  wire fsu_rsvd_bad = (idx_b[7:5] != 3'b000) | (opt_b[7:6] != 2'b00) |
    (opt_b[3:2] != 2'b00);
  wire fsu_txn_bad = !is_txn_file & (opt_b[5] | opt_b[4]);
  wire fsu_lim_low = lim_on & (txn_counter_limit <= txn_ctr_reg);
  // a free change right needs no session, any other needs the change key
  wire fsu_no_auth = !ctrl_reg[`KVF_C_CHGFREE] & !ctrl_reg[`KVF_C_CHGAUTH];

  // version byte of the queried key; a case avoids a select past the store
  always @* begin
    case (idx_b[2:0])
      3'h0: kq_ver = kver_reg[7:0];
      3'h1: kq_ver = kver_reg[15:8];
      3'h2: kq_ver = kver_reg[23:16];
      3'h3: kq_ver = kver_reg[31:24];
      3'h4: kq_ver = kver_reg[39:32];
      default: kq_ver = 8'h00;
    endcase
  end

  // ahb address phase accepted
  wire ahb_go = hsel & htrans[1] & hready;
  wire ctrl_wr = wr_pend_reg & (addr_reg == `KVF_OFF_CTRL);
  wire start = ctrl_wr & hwdata[`KVF_C_START] & state_reg[0];

  // status decision; priority follows the order of the checks
  always @* begin
    sw2_next = `KVF_ST_OK;
    case (cmd_b)
      // key replacement: abort, length and integrity are checked first
      `KVF_CMD_KEYREP: begin
        if (ctrl_reg[`KVF_C_CHAIN])
          sw2_next = `KVF_ST_ABORT;
        else if (len_reg != `KVF_LEN_KEYREP)
          sw2_next = `KVF_ST_LEN;
        else if (!ctrl_reg[`KVF_C_MACOK])
          sw2_next = `KVF_ST_INTEG;
        else if (idx_b[7:6] != 2'b00)
          sw2_next = `KVF_ST_PARAM;
        else if (idx_b[5:0] > `KVF_MAX_KEY)
          sw2_next = `KVF_ST_NOKEY;
        else if (ctrl_reg[`KVF_C_CARD])
          sw2_next = `KVF_ST_DENY;
        else if (!ctrl_reg[`KVF_C_MAUTH])
          sw2_next = `KVF_ST_AUTH;
        else if (ctrl_reg[`KVF_C_NVMFAIL])
          sw2_next = `KVF_ST_NVM;
      end
      // key version query: no card level refusal, origin keys read 00h
      `KVF_CMD_KVQ: begin
        if (ctrl_reg[`KVF_C_CHAIN])
          sw2_next = `KVF_ST_ABORT;
        else if (len_reg != `KVF_LEN_KVQ)
          sw2_next = `KVF_ST_LEN;
        else if (!ctrl_reg[`KVF_C_MACOK])
          sw2_next = `KVF_ST_INTEG;
        else if (idx_b[7:4] != 4'h0)
          sw2_next = `KVF_ST_PARAM;
        else if (idx_b[5:0] > `KVF_MAX_KEY)
          sw2_next = `KVF_ST_NOKEY;
        else if (ctrl_reg[`KVF_C_NVMFAIL])
          sw2_next = `KVF_ST_NVM;
      end
      // file settings update: the frame protection must match the change right
      `KVF_CMD_FSU: begin
        if (ctrl_reg[`KVF_C_CHAIN])
          sw2_next = `KVF_ST_ABORT;
        else if (len_reg != fsu_len)
          sw2_next = `KVF_ST_LEN;
        else if (!ctrl_reg[`KVF_C_MACOK] | fsu_mode_bad)
          sw2_next = `KVF_ST_INTEG;
        else if (fsu_rsvd_bad)
          sw2_next = `KVF_ST_PARAM;
        else if (fsu_txn_bad)
          sw2_next = `KVF_ST_PARAM;
        else if (fsu_lim_low)
          sw2_next = `KVF_ST_PARAM;
        else if (ctrl_reg[`KVF_C_CARD])
          sw2_next = `KVF_ST_DENY;
        else if (!files_reg[file_index])
          sw2_next = `KVF_ST_NOFILE;
        else if (ctrl_reg[`KVF_C_CHGNEVER])
          sw2_next = `KVF_ST_DENY;
        else if (fsu_no_auth)
          sw2_next = `KVF_ST_AUTH;
        else if (ctrl_reg[`KVF_C_NVMFAIL])
          sw2_next = `KVF_ST_NVM;
      end
      // anything else is an unsupported command
      default: sw2_next = `KVF_ST_ILLCMD;
    endcase
  end

  // command sequencer: one cycle to execute, then idle with done set
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_IDLE;
      sw2_reg <= `KVF_ST_OK;
      reply_reg <= 8'h00;
      done_reg <= 1'b0;
      fset_reg <= 32'h00000000;
      limit_reg <= 32'h00000000;
    end else begin
      case (state_reg)
        // idle: a start strobe while busy is simply dropped
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_EXEC;
            done_reg <= 1'b0;
          end
        end
        // one decision cycle; stores change only on success
        ST_EXEC: begin
          state_reg <= ST_IDLE;
          done_reg <= 1'b1;
          sw2_reg <= sw2_next;
          reply_reg <= 8'h00;
          if (sw2_next == `KVF_ST_OK) begin
            if (cmd_b == `KVF_CMD_KVQ)
              reply_reg <= ctrl_reg[`KVF_C_CARD] ? `KVF_ORIGIN_KVER : kq_ver;
            if (cmd_b == `KVF_CMD_FSU) begin
              fset_reg <= {acc_set, opt_b, 3'b000, file_index};
              if (lim_on)
                limit_reg <= txn_counter_limit;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // software-loaded registers; key version store also takes replacements
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `KVF_CTRL_RST;
      frame0_reg <= 32'h00000000;
      frame1_reg <= 32'h00000000;
      frame2_reg <= 8'h00;
      len_reg <= 4'h0;
      kver_reg <= 40'h0000000000;
      files_reg <= 32'h00000000;
      txn_file_reg <= 5'h00;
      txn_ctr_reg <= 32'h00000000;
    end else begin
      // the start bit is a strobe and is never stored
      if (wr_pend_reg) begin
        case (addr_reg)
          `KVF_OFF_CTRL: ctrl_reg <= {hwdata[10:1], 1'b0};
          `KVF_OFF_FRAME0: frame0_reg <= hwdata;
          `KVF_OFF_FRAME1: frame1_reg <= hwdata;
          `KVF_OFF_FRAME2: frame2_reg <= hwdata[7:0];
          `KVF_OFF_LEN: len_reg <= hwdata[3:0];
          `KVF_OFF_KVER0: kver_reg[31:0] <= hwdata;
          `KVF_OFF_KVER1: kver_reg[39:32] <= hwdata[7:0];
          `KVF_OFF_FILES: files_reg <= hwdata;
          `KVF_OFF_TXNFILE: txn_file_reg <= hwdata[4:0];
          `KVF_OFF_TXNCTR: txn_ctr_reg <= hwdata;
          default: ;
        endcase
      end
      // new version byte sits in frame byte 2 once the cryptogram is unwrapped
      if (state_reg[1] & (cmd_b == `KVF_CMD_KEYREP) & (sw2_next == `KVF_ST_OK))
        kver_reg[{idx_b[2:0], 3'b000} +: 8] <= opt_b;
    end
  end

  // read mux, unmapped words read zero
  always @* begin
    case (addr_reg)
      `KVF_OFF_CTRL: rd_mux = {21'h00000, ctrl_reg};
      `KVF_OFF_FRAME0: rd_mux = frame0_reg;
      `KVF_OFF_FRAME1: rd_mux = frame1_reg;
      `KVF_OFF_FRAME2: rd_mux = {24'h000000, frame2_reg};
      `KVF_OFF_LEN: rd_mux = {28'h0000000, len_reg};
      `KVF_OFF_KVER0: rd_mux = kver_reg[31:0];
      `KVF_OFF_KVER1: rd_mux = {24'h000000, kver_reg[39:32]};
      `KVF_OFF_FILES: rd_mux = files_reg;
      `KVF_OFF_TXNFILE: rd_mux = {27'h000000, txn_file_reg};
      `KVF_OFF_TXNCTR: rd_mux = txn_ctr_reg;
      `KVF_OFF_FSET: rd_mux = fset_reg;
      `KVF_OFF_LIMIT: rd_mux = limit_reg;
      `KVF_OFF_STATUS: rd_mux = {reply_reg, 6'h00, state_reg[1], done_reg,
                                 sw2_reg, `KVF_SW1};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ahb slave: writes zero wait; reads take one wait state so that a
  // read right behind a write always sees the written value
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else begin
      hresp <= 1'b0;
      wr_pend_reg <= 1'b0;
      // second cycle of a read: present the word and end the wait
      if (rd_pend_reg) begin
        hrdata <= rd_mux;
        hreadyout <= 1'b1;
        rd_pend_reg <= 1'b0;
      end else if (ahb_go) begin
        // address phase: keep the offset, stall reads for one cycle
        addr_reg <= {haddr[7:2], 2'b00};
        wr_pend_reg <= hwrite;
        rd_pend_reg <= ~hwrite;
        hreadyout <= hwrite;
      end
    end
  end
endmodule // kvf_cmd

// *** testbench/kvf_host.sv ***
// bus master model standing in for the reader side
// assumes hready is the slave's hreadyout looped back
module kvf_host (
  input logic hclk,
  input logic hready,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idle at time zero, word transfers only
  initial {hsel, haddr, htrans, hwrite, hwdata} = '0;
  assign hsize = 3'h2;
  // one single transfer; request held until hready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (!hready);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (!hready);
    hwdata <= ~d; // released data must not look like the old word
  endtask
endmodule // kvf_host

// *** testbench/kvf_cmd_chk.sv ***
// assertions on the register bus of the command interpreter
// sees the top ports only; bound into kvf_cmd below
module kvf_cmd_chk (
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic hready,
  input logic [31:0] hrdata,
  input logic hreadyout,
  input logic hresp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // address phases accepted by the slave
  wire rd = hsel && htrans[1] && hready && !hwrite;
  wire wt = hsel && htrans[1] && hready && hwrite;
  wire st = rd && haddr[7:2] == 6'h0C;
  a_read_wait: assert property (rd |=> !hreadyout ##1 hreadyout) else $error("read wait");
  a_write_nowait: assert property (wt |=> hreadyout) else $error("write stalled");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_stall_once: assert property (!hreadyout |=> hreadyout) else $error("long stall");
  a_sw_first: assert property (st |-> ##2 hrdata[7:0] == 8'h91)
    else $error("status first byte");
  a_code_known: assert property (st |-> ##2 hrdata[15:8] inside
    {8'h00, 8'hCA, 8'h1E, 8'h7E, 8'h9E, 8'h40, 8'h9D, 8'hAE, 8'hEE, 8'hF0, 8'h1C})
    else $error("unknown code");
  a_ver_on_ok: assert property (
    st |-> ##2 (hrdata[31:24] == 8'h00 || hrdata[15:8] == 8'h00)) else $error("version");
  a_done_idle: assert property (st |-> ##2 !(hrdata[16] && hrdata[17])) else $error("done busy");
  a_start_low: assert property ((rd && haddr[7:2] == 6'h00) |-> ##2
    (hrdata[31:11] == 21'h0 && !hrdata[0])) else $error("ctrl readback");
endmodule // kvf_cmd_chk

bind kvf_cmd kvf_cmd_chk kvf_cmd_chk_i (.*);

// *** testbench/kvf_cmd_tb_top.sv ***
// self-checking bench for the key and file command interpreter
// assumes the host model and the bound checker alongside
module kvf_cmd_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 0;
  logic hresetn = 0;
  logic hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, kv;
  logic rd_dp = 0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int failures = 0;
  int total_checks = 0;
  int seed = 85141;
  always #2 hclk = ~hclk;
  kvf_cmd kvf_cmd_i (.hready(hreadyout), .*);
  kvf_host kvf_host_i (.hready(hreadyout), .*);
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    total_checks++;
    if (got !== want) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    kvf_host_i.xfer(1'b1, a, d);
  endtask
  // the note goes on the queue before the read starts
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    exp_q.push_back(e);
    msk_q.push_back(m);
    kvf_host_i.xfer(1'b0, a, 32'h0);
  endtask
  // load a frame, fire it, read status at once (done by then)
  task automatic cmd(input logic [31:0] f0, f1, input logic [3:0] n, input logic [10:0] c,
    input logic [7:0] code, input logic [7:0] ver = 8'h00);
    wr(8'h04, f0);
    wr(8'h08, f1);
    wr(8'h10, {28'h0, n});
    wr(8'h00, {21'h0, c | 11'h001});
    rd(8'h30, {ver, 6'h0, 2'h1, code, 8'h91}, 32'hFF03FFFF);
  endtask
  // a read ends at the first edge with hready high again
  always @(posedge hclk) begin
    if (rd_dp && hreadyout) check(hrdata & msk_q.pop_front(), exp_q.pop_front());
    if (hreadyout) rd_dp <= hsel && htrans[1] && !hwrite;
  end
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #20000;
    failures++;
    wrap_up;
  end
  // main sequence: reset values, key commands, file commands
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(8'h00, 32'h4);
    rd(8'h30, 32'h91);
    rd(8'h34, 32'h0);
    kv = $random(seed);
    wr(8'h14, kv);
    wr(8'h1C, 32'h18);
    wr(8'h20, 32'h4);
    wr(8'h24, 32'hA);
    $display("test reset done");
    for (int k = 0; k < 5; k++)
      cmd({16'h0, 8'(k), 8'h64}, 32'h0, 4'h2, 11'h024, 8'h00,
        k < 4 ? kv[8*k+:8] : 8'h00);
    cmd(32'h005501C4, 32'h0, 4'h3, 11'h026, 8'hCA);
    cmd(32'h005501C4, 32'h0, 4'h3, 11'h020, 8'h1E);
    cmd(32'h0264, 32'h0, 4'h3, 11'h024, 8'h7E);
    cmd(32'h1264, 32'h0, 4'h2, 11'h024, 8'h9E);
    cmd(32'h0564, 32'h0, 4'h2, 11'h024, 8'h40);
    cmd(32'h005545C4, 32'h0, 4'h3, 11'h024, 8'h9E);
    cmd(32'h005505C4, 32'h0, 4'h3, 11'h024, 8'h40);
    cmd(32'h005501C4, 32'h0, 4'h3, 11'h034, 8'h9D);
    cmd(32'h005501C4, 32'h0, 4'h3, 11'h004, 8'hAE);
    cmd(32'h005501C4, 32'h0, 4'h3, 11'h02C, 8'hEE);
    cmd(32'h0164, 32'h0, 4'h2, 11'h020, 8'h1E);
    cmd(32'h0164, 32'h0, 4'h2, 11'h014, 8'h00);
    cmd(32'h005501C4, 32'h0, 4'h3, 11'h024, 8'h00);
    cmd(32'h0164, 32'h0, 4'h2, 11'h024, 8'h00, 8'h55);
    $display("test keys done");
    cmd(32'h3401035F, 32'h12, 4'h5, 11'h084, 8'h00);
    rd(8'h28, 32'h12340103);
    cmd(32'h3401035F, 32'h12, 4'h5, 11'h484, 8'h1E);
    cmd(32'h7802035F, 32'h56, 4'h5, 11'h604, 8'h00);
    rd(8'h28, 32'h56780203);
    cmd(32'h3401235F, 32'h12, 4'h5, 11'h084, 8'h9E);
    cmd(32'h3401005F, 32'h12, 4'h5, 11'h084, 8'hF0);
    cmd(32'h3401035F, 32'h12, 4'h5, 11'h094, 8'h9D);
    cmd(32'h3401035F, 32'h12, 4'h5, 11'h504, 8'h9D);
    cmd(32'h3401035F, 32'h12, 4'h5, 11'h404, 8'hAE);
    cmd(32'h00AA, 32'h0, 4'h1, 11'h024, 8'h1C);
    rd(8'h28, 32'h56780203);
    cmd(32'h0020035F, 32'h0, 4'h9, 11'h084, 8'h9E);
    cmd(32'h0010035F, 32'h0, 4'h5, 11'h084, 8'h9E);
    cmd(32'h0020045F, 32'h0, 4'h5, 11'h084, 8'h7E);
    cmd(32'h0020045F, 32'hA00, 4'h9, 11'h084, 8'h9E);
    cmd(32'h0020045F, 32'hB00, 4'h9, 11'h084, 8'h00);
    rd(8'h2C, 32'hB);
    cmd(32'h0020045F, 32'hC00, 4'h7, 11'h0C4, 8'h00);
    rd(8'h2C, 32'hC);
    $display("test files done");
    @(posedge hclk);
    wrap_up;
  end
endmodule // kvf_cmd_tb_top
